// >>> logic/hwmon_bank_params.svh
/*
 * Constants of the monitor register bank: indexes, reset values, masks,
 * field positions, timing and response codes.
 * Assumes it is included by the package and the bank module.
 */
`ifndef HWMON_BANK_PARAMS_SVH
`define HWMON_BANK_PARAMS_SVH

// ************************************************************
// Register indexes (byte address is four times the index)
// ************************************************************
`define ADDR_W            12
`define IDX_TEMP_SOURCE   8'h4a
`define IDX_BANK_SELECT   8'h4e
`define IDX_MAKER_CODE    8'h4f
`define IDX_BEEP_ONE      8'h56
`define IDX_BEEP_TWO      8'h57
`define IDX_PART_CODE     8'h58
`define IDX_DIODE_DIV     8'h59
`define IDX_BATTERY_CTRL  8'h5d
`define IDX_PWM_FREQ      8'h60
`define IDX_OUTPUT_VALUE  8'h61
`define IDX_FAN_CONFIG    8'h62
`define IDX_FAN_TARGET    8'h63
`define IDX_BATTERY_READ  8'h70
`define IDX_BANKED_LO     8'h50
`define IDX_BANKED_HI     8'h5f

// ************************************************************
// Reset values, writable masks and the target temperature mask
// ************************************************************
`define RST_TEMP_SOURCE   8'h64
`define RST_BANK_SELECT   8'h80
`define RST_BEEP_ONE      8'h00
`define RST_BEEP_TWO      8'h80
`define RST_DIODE_DIV     8'h70
`define RST_BATTERY_CTRL  8'h00
`define RST_PWM_FREQ      8'h04
`define RST_OUTPUT_VALUE  8'hff
`define RST_FAN_CONFIG    8'h40
`define RST_FAN_TARGET    8'h00
`define MASK_BANK_SELECT  8'hb7
`define MASK_BATTERY_CTRL 8'hef
`define MASK_FAN_CONFIG   8'h7f
`define MASK_TARGET_TEMP  8'h7f

// ************************************************************
// Identity codes (values are arbitrary)
// ************************************************************
`define MAKER_CODE        16'h1a2b
`define PART_CODE         8'h3c
`define MAKER_CODE_HI     8'h1a
`define MAKER_CODE_LO     8'h2b

// ************************************************************
// Field positions, prescaler and duty limits, alarm width
// ************************************************************
`define BIT_HIGH_BYTE     7
`define BANK_MSB          2
`define BIT_AUX2_BEEP     5
`define BIT_CPU2_BEEP     4
`define BIT_GLOBAL_BEEP   7
`define BIT_PWM_SLOW      7
`define BIT_OUT_DC        6
`define BIT_BATTERY_EN    0
`define BIT_AUX2_DIV_MSB  7
`define PRESCALE_MAX_CODE 7'h7f
`define PRESCALE_MAX      8'h80
`define DUTY_FULL         8'hff
`define ALARM_W           18

// ************************************************************
// Timing and bus answers
// ************************************************************
`define MCLK_MHZ          10
`define MONITOR_CYCLE_US  1000
`define MONITOR_CYCLES    (`MONITOR_CYCLE_US * `MCLK_MHZ)
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

// >>> logic/hwmon_bank_pkg.sv
/*
 * Types of the monitor register bank.
 * Assumes the constants header is on the include path.
 */
`include "hwmon_bank_params.svh"

package hwmon_bank_pkg;

  // ************************************************************
  // Fan control modes and battery update states
  // ************************************************************
  typedef enum logic [1:0] {
    MODE_MANUAL       = 2'b00,
    MODE_THERMAL      = 2'b01,
    MODE_SPEED        = 2'b10,
    MODE_AUTO         = 2'b11
  } fan_mode_t;

  typedef enum logic [1:0] {
    BAT_IDLE          = 2'b00,
    BAT_WAIT          = 2'b01,
    BAT_LATCH         = 2'b11
  } battery_state_t;

  // ************************************************************
  // Grouped fan settings and divisor codes
  // ************************************************************
  typedef struct packed {
    fan_mode_t        mode;
    logic [3:0]       tolerance;
    logic [7:0]       target;
    logic [1:0]       temp_source;
  } fan_setting_t;

  typedef struct packed {
    logic [2:0]       primary_msb;
    logic [2:0]       aux_secondary;
    logic [1:0]       cpu_secondary_low;
  } divisor_codes_t;

endpackage

// >>> logic/hwmon_bank.sv
/*
 * Hardware-monitor register bank: bank select, maker and part codes,
 * beep enables and beep output, sensor and divisor selection, battery
 * monitor control, and one fan output with PWM and DC level.
 * Assumes an AXI4-Lite master on MCLK, prescaler source ticks from
 * same-clock logic, and alarm flags and battery value from outside.
 */
`timescale 1ns/1ps
`include "hwmon_bank_params.svh"

module hwmon_bank #(
  parameter int unsigned MONITOR_CYCLES = `MONITOR_CYCLES
) (
  input  wire logic                             MCLK,
  input  wire logic                             RST_N,
  input  wire logic [`ADDR_W-1:0]               AWADDR,
  input  wire logic                             AWVALID,
  output logic                                  AWREADY,
  input  wire logic [31:0]                      WDATA,
  input  wire logic [3:0]                       WSTRB,
  input  wire logic                             WVALID,
  output logic                                  WREADY,
  output logic [1:0]                            BRESP,
  output logic                                  BVALID,
  input  wire logic                             BREADY,
  input  wire logic [`ADDR_W-1:0]               ARADDR,
  input  wire logic                             ARVALID,
  output logic                                  ARREADY,
  output logic [31:0]                           RDATA,
  output logic [1:0]                            RRESP,
  output logic                                  RVALID,
  input  wire logic                             RREADY,
  input  wire logic [`ALARM_W-1:0]              ALARM_FLAGS,
  input  wire logic [7:0]                       BATTERY_VALUE,
  input  wire logic                             FAST_SRC_TICK,
  input  wire logic                             SLOW_SRC_TICK,
  output logic                                  BEEP,
  output logic                                  FAN_PWM,
  output logic [5:0]                            FAN_DC_LEVEL,
  output logic                                  FAN_IS_DC,
  output hwmon_bank_pkg::fan_setting_t          FAN_SETTING,
  output hwmon_bank_pkg::divisor_codes_t        DIVISOR_CODES,
  output logic [2:0]                            SENSOR_IS_DIODE,
  output logic [2:0]                            DIODE_MODE,
  output logic [2:0]                            BANK,
  output logic                                  BATTERY_MONITOR_EN
);
  import hwmon_bank_pkg::*;

  // ************************************************************
  // Address decoding
  // ************************************************************
  function automatic logic [7:0] reg_index(input logic [`ADDR_W-1:0] addr);
    reg_index = addr[9:2];
  endfunction

  function automatic logic index_hit(input logic [`ADDR_W-1:0] addr,
                                     input logic [2:0] bank_now);
    logic [7:0] idx;
    idx = reg_index(addr);
    index_hit = 1'b0;
    if (addr[`ADDR_W-1:10] == '0) begin
      unique case (idx)
        `IDX_TEMP_SOURCE, `IDX_BANK_SELECT, `IDX_MAKER_CODE, `IDX_PWM_FREQ,
        `IDX_OUTPUT_VALUE, `IDX_FAN_CONFIG, `IDX_FAN_TARGET,
        `IDX_BATTERY_READ: begin
          index_hit = 1'b1;
        end
        `IDX_BEEP_ONE, `IDX_BEEP_TWO, `IDX_PART_CODE, `IDX_DIODE_DIV,
        `IDX_BATTERY_CTRL: begin
          index_hit = (bank_now == 3'h0);
        end
        default: begin
          index_hit = 1'b0;
        end
      endcase
    end
  endfunction

  // ************************************************************
  // Storage
  // ************************************************************
  logic [7:0]                 temp_source;
  logic [7:0]                 bank_select;
  logic [7:0]                 beep_one;
  logic [7:0]                 beep_two;
  logic [7:0]                 diode_div;
  logic [7:0]                 battery_ctrl;
  logic [7:0]                 pwm_freq;
  logic [7:0]                 output_value;
  logic [7:0]                 fan_config;
  logic [7:0]                 fan_target;
  logic [7:0]                 battery_reading;
  logic [`ALARM_W-1:0]        alarm_meta;
  logic [`ALARM_W-1:0]        alarm_sync;
  logic [7:0]                 battery_meta;
  logic [7:0]                 battery_sync;
  battery_state_t             battery_state;
  logic [31:0]                monitor_count;
  logic [7:0]                 prescale_count;
  logic [7:0]                 pwm_count;

  // ************************************************************
  // Bus handshake decode
  // ************************************************************
  wire        write_take   = AWVALID & WVALID & ~AWREADY & ~BVALID;
  wire        write_fire   = AWREADY & AWVALID;
  wire        write_hit    = index_hit(AWADDR, bank_select[`BANK_MSB:0]);
  wire        write_lane   = write_fire & write_hit & WSTRB[0];
  wire [7:0]  write_index  = reg_index(AWADDR);
  wire [7:0]  wbyte        = WDATA[7:0];
  wire        read_take    = ARVALID & ~ARREADY & ~RVALID;
  wire        read_fire    = ARREADY & ARVALID;
  wire        read_hit     = index_hit(ARADDR, bank_select[`BANK_MSB:0]);
  wire [7:0]  read_index   = reg_index(ARADDR);

  wire we_temp_source  = write_lane & (write_index == `IDX_TEMP_SOURCE);
  wire we_bank_select  = write_lane & (write_index == `IDX_BANK_SELECT);
  wire we_beep_one     = write_lane & (write_index == `IDX_BEEP_ONE);
  wire we_beep_two     = write_lane & (write_index == `IDX_BEEP_TWO);
  wire we_diode_div    = write_lane & (write_index == `IDX_DIODE_DIV);
  wire we_battery_ctrl = write_lane & (write_index == `IDX_BATTERY_CTRL);
  wire we_pwm_freq     = write_lane & (write_index == `IDX_PWM_FREQ);
  wire we_output_value = write_lane & (write_index == `IDX_OUTPUT_VALUE);
  wire we_fan_config   = write_lane & (write_index == `IDX_FAN_CONFIG);
  wire we_fan_target   = write_lane & (write_index == `IDX_FAN_TARGET);

  wire [7:0]  maker_byte   = bank_select[`BIT_HIGH_BYTE] ? `MAKER_CODE_HI : `MAKER_CODE_LO;

  logic [7:0] read_byte;
  always_comb begin
    read_byte = 8'h00;
    unique case (read_index)
      `IDX_TEMP_SOURCE:  read_byte = temp_source;
      `IDX_BANK_SELECT:  read_byte = bank_select;
      `IDX_MAKER_CODE:   read_byte = maker_byte;
      `IDX_BEEP_ONE:     read_byte = beep_one;
      `IDX_BEEP_TWO:     read_byte = beep_two;
      `IDX_PART_CODE:    read_byte = `PART_CODE;
      `IDX_DIODE_DIV:    read_byte = diode_div;
      `IDX_BATTERY_CTRL: read_byte = battery_ctrl;
      `IDX_PWM_FREQ:     read_byte = pwm_freq;
      `IDX_OUTPUT_VALUE: read_byte = output_value;
      `IDX_FAN_CONFIG:   read_byte = fan_config;
      `IDX_FAN_TARGET:   read_byte = fan_target;
      `IDX_BATTERY_READ: read_byte = battery_reading;
      default:           read_byte = 8'h00;
    endcase
  end

  // ************************************************************
  // AXI4-Lite channels
  // ************************************************************
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      AWREADY <= 1'b0;
      WREADY  <= 1'b0;
      BVALID  <= 1'b0;
      BRESP   <= `RESP_OKAY;
    end else begin
      AWREADY <= write_take;
      WREADY  <= write_take;
      if (write_fire) begin
        BVALID <= 1'b1;
        BRESP  <= write_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= 32'h0000_0000;
      RRESP   <= `RESP_OKAY;
    end else begin
      ARREADY <= read_take;
      if (read_fire) begin
        RVALID <= 1'b1;
        RDATA  <= {24'h00_0000, read_hit ? read_byte : 8'h00};
        RRESP  <= read_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Writable registers
  // ************************************************************
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      temp_source  <= `RST_TEMP_SOURCE;
      bank_select  <= `RST_BANK_SELECT;
      beep_one     <= `RST_BEEP_ONE;
      beep_two     <= `RST_BEEP_TWO;
      diode_div    <= `RST_DIODE_DIV;
      battery_ctrl <= `RST_BATTERY_CTRL;
      pwm_freq     <= `RST_PWM_FREQ;
      output_value <= `RST_OUTPUT_VALUE;
      fan_config   <= `RST_FAN_CONFIG;
      fan_target   <= `RST_FAN_TARGET;
    end else begin
      if (we_temp_source)  temp_source  <= wbyte;
      if (we_bank_select)  bank_select  <= wbyte & `MASK_BANK_SELECT;
      if (we_beep_one)     beep_one     <= wbyte;
      if (we_beep_two)     beep_two     <= wbyte;
      if (we_diode_div)    diode_div    <= wbyte;
      if (we_battery_ctrl) battery_ctrl <= wbyte & `MASK_BATTERY_CTRL;
      if (we_pwm_freq)     pwm_freq     <= wbyte;
      if (we_output_value) output_value <= wbyte;
      if (we_fan_config)   fan_config   <= wbyte & `MASK_FAN_CONFIG;
      if (we_fan_target)   fan_target   <= wbyte;
    end
  end

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      alarm_meta   <= '0;
      alarm_sync   <= '0;
      battery_meta <= 8'h00;
      battery_sync <= 8'h00;
    end else begin
      alarm_meta   <= ALARM_FLAGS;
      alarm_sync   <= alarm_meta;
      battery_meta <= BATTERY_VALUE;
      battery_sync <= battery_meta;
    end
  end

  // ************************************************************
  // Battery reading update
  // ************************************************************
  wire battery_rise = we_battery_ctrl & wbyte[`BIT_BATTERY_EN]
                      & ~battery_ctrl[`BIT_BATTERY_EN];
  wire monitor_done = (monitor_count >= MONITOR_CYCLES - 1);

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      battery_state   <= BAT_IDLE;
      monitor_count   <= 32'h0000_0000;
      battery_reading <= 8'h00;
    end else begin
      unique case (battery_state)
        BAT_IDLE: begin
          monitor_count <= 32'h0000_0000;
          if (battery_rise) battery_state <= BAT_WAIT;
        end
        BAT_WAIT: begin
          monitor_count <= monitor_count + 32'h0000_0001;
          if (!battery_ctrl[`BIT_BATTERY_EN]) battery_state <= BAT_IDLE;
          else if (monitor_done) battery_state <= BAT_LATCH;
        end
        BAT_LATCH: begin
          battery_reading <= battery_sync;
          battery_state   <= BAT_IDLE;
        end
        default: begin
          battery_state <= BAT_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Beep
  // ************************************************************
  // enable vector
  wire [`ALARM_W-1:0] beep_enables = {bank_select[`BIT_AUX2_BEEP], bank_select[`BIT_CPU2_BEEP],
                                      beep_two[6:0], beep_one[0 +: 8], 1'b0};
  wire next_beep = beep_two[`BIT_GLOBAL_BEEP] & |(beep_enables & alarm_sync);

  // ************************************************************
  // PWM prescaler and counter
  // ************************************************************
  // clock source select
  wire       src_tick   = pwm_freq[`BIT_PWM_SLOW] ? SLOW_SRC_TICK : FAST_SRC_TICK;
  wire [6:0] div_code   = pwm_freq[6:0];
  wire [7:0] divider    = (div_code == `PRESCALE_MAX_CODE) ? `PRESCALE_MAX :
                          (div_code == 7'h00) ? 8'h01 : {1'b0, div_code};
  wire       pre_wrap   = src_tick & (prescale_count >= divider - 8'h01);
  wire       next_pwm   = (output_value == `DUTY_FULL) | (pwm_count < output_value);
  wire       dc_mode    = fan_config[`BIT_OUT_DC];

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      prescale_count <= 8'h00;
      pwm_count      <= 8'h00;
    end else begin
      if (pre_wrap) prescale_count <= 8'h00;
      else if (src_tick) prescale_count <= prescale_count + 8'h01;
      if (pre_wrap) pwm_count <= pwm_count + 8'h01;
    end
  end

  // ************************************************************
  // Registered outputs
  // ************************************************************
  fan_setting_t   next_setting;
  divisor_codes_t next_divisors;
  always_comb begin
    next_setting.mode        = fan_mode_t'(fan_config[5:4]);
    next_setting.tolerance   = fan_config[3:0];
    next_setting.target      = (fan_config[5:4] == MODE_SPEED) ? fan_target :
                               (fan_target & `MASK_TARGET_TEMP);
    next_setting.temp_source = temp_source[7:6];
    next_divisors.primary_msb       = battery_ctrl[7:5];
    next_divisors.aux_secondary     = {diode_div[`BIT_AUX2_DIV_MSB], diode_div[3:2]};
    next_divisors.cpu_secondary_low = diode_div[1:0];
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      BEEP               <= 1'b0;
      FAN_PWM            <= 1'b0;
      FAN_DC_LEVEL       <= 6'h00;
      FAN_IS_DC          <= 1'b1;
      FAN_SETTING        <= '0;
      DIVISOR_CODES      <= '0;
      SENSOR_IS_DIODE    <= 3'h0;
      DIODE_MODE         <= 3'h0;
      BANK               <= 3'h0;
      BATTERY_MONITOR_EN <= 1'b0;
    end else begin
      BEEP               <= next_beep;
      FAN_IS_DC          <= dc_mode;
      FAN_PWM            <= ~dc_mode & next_pwm;
      FAN_DC_LEVEL       <= dc_mode ? output_value[7:2] : 6'h00;
      FAN_SETTING        <= next_setting;
      DIVISOR_CODES      <= next_divisors;
      SENSOR_IS_DIODE    <= battery_ctrl[3:1];
      DIODE_MODE         <= diode_div[6:4] & battery_ctrl[3:1];
      BANK               <= bank_select[`BANK_MSB:0];
      BATTERY_MONITOR_EN <= battery_ctrl[`BIT_BATTERY_EN];
    end
  end

endmodule // hwmon_bank

// >>> test/hwmon_bank_assertions.sv
/* Checker for the monitor register bank.
   Bound to hwmon_bank; watches a subset of its ports. */
`timescale 1ns/1ps
`include "hwmon_bank_params.svh"
module hwmon_bank_assertions (
  input wire logic                         MCLK,
  input wire logic                         RST_N,
  input wire logic                         AWREADY,
  input wire logic                         WREADY,
  input wire logic                         BVALID,
  input wire logic                         ARREADY,
  input wire logic                         RVALID,
  input wire logic [31:0]                  RDATA,
  input wire logic [`ALARM_W-1:0]          ALARM_FLAGS,
  input wire logic                         BEEP,
  input wire logic                         FAN_PWM,
  input wire logic [5:0]                   FAN_DC_LEVEL,
  input wire logic                         FAN_IS_DC,
  input wire hwmon_bank_pkg::fan_setting_t FAN_SETTING,
  input wire logic [2:0]                   SENSOR_IS_DIODE,
  input wire logic [2:0]                   DIODE_MODE,
  input wire logic [2:0]                   BANK
);
  import hwmon_bank_pkg::*;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // ************************************************************
  // Properties
  // ************************************************************
  sequence s_quiet; (ALARM_FLAGS == 18'h0) [*5]; endsequence
  sequence s_wr_taken; AWREADY && WREADY; endsequence
  property p_write_answer; s_wr_taken |=> BVALID && !AWREADY; endproperty
  a_write_answer: assert property (p_write_answer) else $error("write answer late");
  property p_read_answer; ARREADY |=> RVALID && RDATA[31:8] == 24'h0; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer wrong");
  property p_ready_pair; AWREADY |-> WREADY; endproperty
  a_ready_pair: assert property (p_ready_pair) else $error("ready split");
  property p_bank_change; $changed(BANK) |-> $past(BVALID) || $past(BVALID, 2); endproperty
  a_bank_change: assert property (p_bank_change) else $error("bank moved alone");
  property p_diode_gate; (DIODE_MODE & ~SENSOR_IS_DIODE) == 3'h0; endproperty
  a_diode_gate: assert property (p_diode_gate) else $error("diode mode ungated");
  property p_pwm_off; FAN_IS_DC && $past(FAN_IS_DC) |-> !FAN_PWM; endproperty
  a_pwm_off: assert property (p_pwm_off) else $error("pwm in dc mode");
  property p_dc_off; !FAN_IS_DC && !$past(FAN_IS_DC) |-> FAN_DC_LEVEL == 6'h00; endproperty
  a_dc_off: assert property (p_dc_off) else $error("dc level in pwm mode");
  property p_target; FAN_SETTING.mode != MODE_SPEED |-> !FAN_SETTING.target[7]; endproperty
  a_target: assert property (p_target) else $error("target too wide");
  property p_beep_quiet; s_quiet |-> !BEEP; endproperty
  a_beep_quiet: assert property (p_beep_quiet) else $error("beep without cause");
endmodule // hwmon_bank_assertions

bind hwmon_bank hwmon_bank_assertions u_chk (
  .MCLK, .RST_N, .AWREADY, .WREADY, .BVALID, .ARREADY, .RVALID, .RDATA, .ALARM_FLAGS, .BEEP,
  .FAN_PWM, .FAN_DC_LEVEL, .FAN_IS_DC, .FAN_SETTING, .SENSOR_IS_DIODE, .DIODE_MODE, .BANK
);

// >>> test/hwmon_far_side.sv
/* Far side: sensor alarm flags, battery value and source clock ticks.
   Assumes the bank clock; ticks stand in for the two source clocks. */
`timescale 1ns/1ps
module hwmon_far_side (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [17:0] alarm_req,
  input  wire logic [7:0]  battery_req,
  output logic [17:0]      alarm_flags,
  output logic [7:0]       battery_value,
  output logic             fast_tick,
  output logic             slow_tick
);
  logic [2:0] cnt;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 3'h0;
    end else begin
      cnt <= cnt + 3'h1;
    end
  end
  assign fast_tick = cnt[0];
  assign slow_tick = (cnt == 3'h7);
  assign alarm_flags = alarm_req;
  assign battery_value = battery_req;
endmodule // hwmon_far_side

// >>> test/testbench.sv
/* Self-checking bench for the monitor register bank.
   AXI4-Lite tasks; the far-side model drives flags and ticks. */
`timescale 1ns/1ps
`include "hwmon_bank_params.svh"
module testbench;
  import hwmon_bank_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic beep, fan_pwm, fan_is_dc, bat_en, fast_tick, slow_tick;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp;
  logic [17:0] alarm_req = 18'h0, alarm_flags;
  logic [7:0] bat_req = 8'h5a, bat_val, rd;
  logic [5:0] dc_level;
  logic [2:0] is_diode, diode_mode, bank;
  fan_setting_t fset;
  divisor_codes_t divs;
  int miscompares = 0, check_count = 0, cycles = 0, n;
  logic [15:0] rst_tab [9] = '{16'h4e80, 16'h5600, 16'h5780, {8'h58, `PART_CODE}, 16'h5970,
                               16'h5d00, 16'h6004, 16'h61ff, 16'h6300};
  logic [31:0] pwm_tab [4] = '{32'h01800400, 32'h01000000, 32'h01ff0800, 32'h81400200};
  always #50 mclk = ~mclk;
  hwmon_bank #(.MONITOR_CYCLES(20)) DUT (
    .MCLK(mclk), .RST_N(rst_n), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .ALARM_FLAGS(alarm_flags),
    .BATTERY_VALUE(bat_val), .FAST_SRC_TICK(fast_tick), .SLOW_SRC_TICK(slow_tick), .BEEP(beep),
    .FAN_PWM(fan_pwm), .FAN_DC_LEVEL(dc_level), .FAN_IS_DC(fan_is_dc), .FAN_SETTING(fset),
    .DIVISOR_CODES(divs), .SENSOR_IS_DIODE(is_diode), .DIODE_MODE(diode_mode), .BANK(bank),
    .BATTERY_MONITOR_EN(bat_en));
  hwmon_far_side u_far (.mclk(mclk), .rst_n(rst_n), .alarm_req(alarm_req),
    .battery_req(bat_req), .alarm_flags(alarm_flags), .battery_value(bat_val),
    .fast_tick(fast_tick), .slow_tick(slow_tick));
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic chk(input string what, input logic [31:0] exp, got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic acc(input bit w, input logic [7:0] idx, d, input logic [1:0] er);
    @(posedge mclk);
    awaddr <= {2'b00, idx, 2'b00};
    araddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= w;
    wvalid <= w;
    bready <= w;
    arvalid <= !w;
    rready <= !w;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
    end while ((w ? bvalid : rvalid) !== 1'b1);
    bready <= 1'b0;
    rready <= 1'b0;
    rd = rdata[7:0];
    repeat (2) @(posedge mclk);
    chk("resp", {30'h0, er}, w ? bresp : rresp);
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    acc(0, idx, 8'h0, `RESP_OKAY);
    chk($sformatf("reg %h", idx), exp, {24'h0, rd});
  endtask
  task automatic beepchk(input logic [17:0] flags, input logic exp);
    alarm_req <= flags;
    repeat (6) @(posedge mclk);
    chk("beep", {31'h0, exp}, {31'h0, beep});
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      print_verdict();
    end
  end
  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (rst_tab[i]) rdchk(rst_tab[i][15:8], {24'h0, rst_tab[i][7:0]});
    rdchk(`IDX_MAKER_CODE, 32'(`MAKER_CODE >> 8));
    chk("fan dc", 32'h1, {31'h0, fan_is_dc});
    chk("temp src", 32'h1, {30'h0, fset.temp_source});
    acc(1, `IDX_TEMP_SOURCE, 8'h80, `RESP_OKAY);
    chk("temp src", 32'h2, {30'h0, fset.temp_source});
    acc(0, 8'h7f, 8'h0, `RESP_SLVERR);
    acc(1, `IDX_BANK_SELECT, 8'h03, `RESP_OKAY);
    chk("bank", 32'h3, {29'h0, bank});
    acc(0, `IDX_BEEP_ONE, 8'h0, `RESP_SLVERR);
    acc(1, `IDX_BANK_SELECT, 8'h30, `RESP_OKAY);
    rdchk(`IDX_MAKER_CODE, `MAKER_CODE & 16'h00ff);
    beepchk(18'h10000, 1'b1);
    beepchk(18'h00000, 1'b0);
    acc(1, `IDX_BEEP_ONE, 8'h80, `RESP_OKAY);
    beepchk(18'h00100, 1'b1);
    beepchk(18'h00002, 1'b0);
    acc(1, `IDX_BEEP_TWO, 8'h10, `RESP_OKAY);
    beepchk(18'h02100, 1'b0);
    acc(1, `IDX_BEEP_TWO, 8'h90, `RESP_OKAY);
    beepchk(18'h02000, 1'b1);
    beepchk(18'h00000, 1'b0);
    acc(1, `IDX_BATTERY_CTRL, 8'hab, `RESP_OKAY);
    rdchk(`IDX_BATTERY_READ, 32'h0);
    acc(1, `IDX_DIODE_DIV, 8'hfe, `RESP_OKAY);
    chk("diode", 32'h5, {29'h0, is_diode});
    chk("diode mode", 32'h5, {29'h0, diode_mode});
    chk("divisors", 32'hbe, {24'h0, divs});
    chk("bat en", 32'h1, {31'h0, bat_en});
    repeat (30) @(posedge mclk);
    rdchk(`IDX_BATTERY_READ, {24'h0, bat_req});
    acc(1, `IDX_FAN_TARGET, 8'hff, `RESP_OKAY);
    for (int m = 0; m < 4; m++) begin
      acc(1, `IDX_FAN_CONFIG, {2'b01, m[1:0], 4'(m + 3)}, `RESP_OKAY);
      chk("mode", m, {30'h0, fset.mode});
      chk("tolerance", m + 3, {28'h0, fset.tolerance});
      chk("target", (m == 2) ? 32'hff : 32'h7f, {24'h0, fset.target});
    end
    acc(1, `IDX_OUTPUT_VALUE, 8'hab, `RESP_OKAY);
    chk("dc level", 32'h2a, {26'h0, dc_level});
    wstrb <= 4'h0;
    acc(1, `IDX_OUTPUT_VALUE, 8'h00, `RESP_OKAY);
    wstrb <= 4'hf;
    chk("dc level", 32'h2a, {26'h0, dc_level});
    acc(1, `IDX_FAN_CONFIG, 8'h00, `RESP_OKAY);
    foreach (pwm_tab[i]) begin
      acc(1, `IDX_PWM_FREQ, pwm_tab[i][31:24], `RESP_OKAY);
      acc(1, `IDX_OUTPUT_VALUE, pwm_tab[i][23:16], `RESP_OKAY);
      repeat (10) @(posedge mclk);
      n = 0;
      repeat (2048) begin
        @(posedge mclk);
        n += (fan_pwm === 1'b1);
      end
      chk("pwm high", {16'h0, pwm_tab[i][15:0]}, n);
    end
    print_verdict();
  end
endmodule // testbench
